//--- rtl/rpd_pkg.sv
// Constants and helpers for the remote pulse decoder
package rpd_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam int         ADDR_W     = 12;
    localparam logic [11:0] OFS_CTRL_A = 12'hFE8;
    localparam logic [11:0] OFS_CTRL_B = 12'hFE9;
    localparam logic [11:0] OFS_CAP    = 12'hFEA;
    localparam logic [11:0] OFS_BUF    = 12'hFEB;
    localparam logic [11:0] OFS_STAT   = 12'hFEC;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int A_CCK_LSB  = 6;
    localparam int A_POL_BIT  = 5;
    localparam int A_SRC_LSB  = 3;
    localparam int A_NF_LSB   = 0;
    localparam int B_THR_LSB  = 4;
    localparam int B_RUN_BIT  = 3;
    localparam int B_EN_BIT   = 2;
    localparam int B_MM_LSB   = 0;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0] CTRL_A_RST  = 8'h00;
    localparam logic [7:0] CTRL_B_RST  = 8'h00;
    localparam logic [7:0] CAP_RST     = 8'h00;
    localparam logic [7:0] BUF_RST     = 8'h00;
    localparam logic [3:0] BCNT_RST    = 4'h0;
    localparam logic [3:0] BCNT_FRAME  = 4'h8;
    localparam logic [3:0] BCNT_RELOAD = 4'h1;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam int         NF_MULT     = 7;
    localparam int         NF_CW       = 14;

    // ****************************************
    // Mode codes
    // ****************************************
    typedef enum logic [1:0] {
        RPD_SRC_RISE  = 2'h0,
        RPD_SRC_FALL  = 2'h1,
        RPD_SRC_BOTH  = 2'h2,
        RPD_SRC_RXEND = 2'h3
    } rpd_src_t;

    typedef enum logic [1:0] {
        RPD_MM_RCYC = 2'h0,
        RPD_MM_FCYC = 2'h1,
        RPD_MM_HIGH = 2'h2,
        RPD_MM_LOW  = 2'h3
    } rpd_mm_t;

    // Prescaler tap: one tick every 2^6/2^8/2^10/2^12 clocks
    function automatic logic rpd_div_tick(input logic [11:0] pre,
                                          input logic [1:0]  sel);
        logic [11:0] mask;
        mask = 12'h03F;
        case (sel)
            2'h0: mask = 12'h03F;
            2'h1: mask = 12'h0FF;
            2'h2: mask = 12'h3FF;
            2'h3: mask = 12'hFFF;
        endcase
        return (pre & mask) == mask;
    endfunction

    // Filter exponent per code; 0 means bypass
    function automatic int rpd_nf_k(input logic [2:0] code);
        int k;
        k = 0;
        case (code)
            3'h1: k = 2;
            3'h2: k = 5;
            3'h3: k = 6;
            3'h4: k = 7;
            3'h5: k = 8;
            3'h6: k = 10;
            3'h7: k = 11;
            default: k = 0;
        endcase
        return k;
    endfunction

endpackage

//--- rtl/rpd_noise_filter.sv
// Noise canceller for the remote input
`timescale 1ns/1ps
module rpd_noise_filter
    import rpd_pkg::*;
#(
    parameter int NF_SHIFT = 0          // Shortens filter times in sim
) (
    input  wire logic       clk,        // System clock
    input  wire logic       rst_n,      // Synchronised reset
    input  wire logic       din,        // Raw input
    input  wire logic [2:0] code,       // Filter time select
    output logic            dout        // Filtered level
);

    logic [NF_CW-1:0] cnt;
    logic [NF_CW-1:0] next_cnt;
    logic             next_dout;
    logic [NF_CW-1:0] lim;
    int               kk;

    // ****************************************
    // Stability counter
    // ****************************************
    always_comb begin
        kk = rpd_nf_k(code) - NF_SHIFT;
        if (kk < 0) begin
            kk = 0;
        end
        lim       = NF_CW'(NF_MULT << kk);
        next_dout = dout;
        next_cnt  = '0;
        if (code == 3'h0) begin
            next_dout = din;
        end else if (din != dout) begin
            if (cnt + 1'b1 >= lim) begin
                next_dout = din;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            dout <= next_dout;
        end
    end

endmodule

//--- rtl/rpd_top.sv
// Remote control pulse decoder: filter, measure, decode, registers
`timescale 1ns/1ps
module rpd_top
    import rpd_pkg::*;
#(
    parameter int NF_SHIFT = 0          // Filter time reduction
) (
    input  wire logic        sys_clk,      // 100 MHz clock
    input  wire logic        nrst,         // Async reset
    input  wire logic [11:0] addr,         // Register address
    input  wire logic [7:0]  wr_data,      // Write data
    input  wire logic        wr_en,        // Write strobe
    input  wire logic        rd_en,        // Read strobe
    output logic      [7:0]  rd_data,      // Read data
    input  wire logic        remote_input, // Demodulated signal
    output logic             remote_irq    // Interrupt pulse
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] next_ctrl_a;
    logic [7:0] next_ctrl_b;
    logic [7:0] next_rd_data;
    logic [7:0] cap;
    logic [7:0] rbuf;
    logic [3:0] bcnt;
    logic       ovf;
    logic       bit_dec;
    logic       filt;
    logic       wr_b;

    logic [1:0] count_clock_select;
    logic       input_polarity;
    rpd_src_t   irq_source_select;
    logic [2:0] noise_filter_time;
    logic [3:0] threshold_nibble;
    logic       counter_run;
    logic       preproc_enable;
    rpd_mm_t    measure_mode;

    assign count_clock_select = ctrl_a[A_CCK_LSB +: 2];
    assign input_polarity     = ctrl_a[A_POL_BIT];
    assign irq_source_select  = rpd_src_t'(ctrl_a[A_SRC_LSB +: 2]);
    assign noise_filter_time  = ctrl_a[A_NF_LSB +: 3];
    assign threshold_nibble   = ctrl_b[B_THR_LSB +: 4];
    assign counter_run        = ctrl_b[B_RUN_BIT];
    assign preproc_enable     = ctrl_b[B_EN_BIT];
    assign measure_mode       = rpd_mm_t'(ctrl_b[B_MM_LSB +: 2]);
    assign wr_b               = wr_en && (addr == OFS_CTRL_B);

    always_comb begin
        next_ctrl_a  = ctrl_a;
        next_ctrl_b  = ctrl_b;
        next_rd_data = 8'h00;
        if (wr_en && addr == OFS_CTRL_A) begin
            next_ctrl_a = wr_data;
        end
        if (wr_b) begin
            next_ctrl_b = wr_data;
        end
        if (rd_en) begin
            unique case (addr)
                OFS_CTRL_A: next_rd_data = ctrl_a;
                OFS_CTRL_B: next_rd_data = ctrl_b;
                OFS_CAP:    next_rd_data = cap;
                OFS_BUF:    next_rd_data = rbuf;
                OFS_STAT:   next_rd_data =
                    {bcnt, 1'b0, ovf, bit_dec, filt};
                default:    next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a  <= CTRL_A_RST;
            ctrl_b  <= CTRL_B_RST;
            rd_data <= 8'h00;
        end else begin
            ctrl_a  <= next_ctrl_a;
            ctrl_b  <= next_ctrl_b;
            rd_data <= next_rd_data;
        end
    end

    // ****************************************
    // Input path
    // ****************************************
    logic sig;
    logic sig_d;
    logic rise;
    logic fall;

    rpd_noise_filter #(
        .NF_SHIFT (NF_SHIFT)
    ) u_filter (
        .clk  (sys_clk),
        .rst_n(rst_n),
        .din  (remote_input),
        .code (noise_filter_time),
        .dout (filt)
    );

    assign sig  = filt ^ input_polarity;
    assign rise = sig && !sig_d;
    assign fall = !sig && sig_d;

    // ****************************************
    // Count clock prescaler
    // ****************************************
    logic [11:0] pre;
    logic [11:0] next_pre;
    logic        tick;

    always_comb begin
        next_pre = pre + 12'h001;
        tick     = rpd_div_tick(pre, count_clock_select);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre <= 12'h000;
        end else begin
            pre <= next_pre;
        end
    end

    // ****************************************
    // Measurement and decoding
    // ****************************************
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] next_cap;
    logic [7:0] next_rbuf;
    logic [3:0] next_bcnt;
    logic       next_ovf;
    logic       next_irq;
    logic       active;
    logic       meas_end;
    logic       gate;

    assign active  = preproc_enable && counter_run;
    assign bit_dec = active && (cnt[7:4] >= threshold_nibble);

    always_comb begin
        unique case (irq_source_select)
            RPD_SRC_RISE:  meas_end = rise;
            RPD_SRC_FALL:  meas_end = fall;
            RPD_SRC_BOTH:  meas_end = rise || fall;
            RPD_SRC_RXEND: meas_end = rise;
        endcase
        if (irq_source_select == RPD_SRC_BOTH) begin
            gate = 1'b1;
        end else begin
            unique case (measure_mode)
                RPD_MM_HIGH: gate = sig;
                RPD_MM_LOW:  gate = !sig;
                default:     gate = 1'b1;
            endcase
        end
    end

    always_comb begin
        next_cnt  = cnt;
        next_cap  = cap;
        next_rbuf = rbuf;
        next_bcnt = bcnt;
        next_ovf  = ovf;
        next_irq  = 1'b0;
        if (wr_b && wr_data[B_RUN_BIT]) begin
            next_ovf = 1'b0;
        end
        if (!active) begin
            next_cnt = 8'h00;
        end else if (meas_end) begin
            next_cap = cnt;
            next_cnt = 8'h00;
            if (irq_source_select == RPD_SRC_RXEND) begin
                next_rbuf = {rbuf[6:0], bit_dec};
                if (bcnt == BCNT_FRAME) begin
                    next_bcnt = BCNT_RELOAD;
                end else begin
                    next_bcnt = bcnt + 4'h1;
                end
                next_irq = (next_bcnt == BCNT_FRAME);
            end else begin
                next_irq = 1'b1;
            end
        end else if (!ovf && tick && gate) begin
            if (cnt == CNT_MAX) begin
                next_cnt = 8'h00;
                next_ovf = 1'b1;
                next_irq = 1'b1;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_d      <= 1'b0;
            cnt        <= 8'h00;
            cap        <= CAP_RST;
            rbuf       <= BUF_RST;
            bcnt       <= BCNT_RST;
            ovf        <= 1'b0;
            remote_irq <= 1'b0;
        end else begin
            sig_d      <= sig;
            cnt        <= next_cnt;
            cap        <= next_cap;
            rbuf       <= next_rbuf;
            bcnt       <= next_bcnt;
            ovf        <= next_ovf;
            remote_irq <= next_irq;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_cap_readonly: assert property (
        wr_en && addr == OFS_CAP && !(active && meas_end)
        |=> $stable(cap))
        else $error("capture register changed by write");

    a_buf_readonly: assert property (
        wr_en && addr == OFS_BUF && !(active && meas_end)
        |=> $stable(rbuf))
        else $error("bit buffer changed by write");

    a_stop_clear: assert property (
        !counter_run |=> cnt == 8'h00)
        else $error("stopped counter not zero");

    a_meas_capture: assert property (
        active && meas_end && irq_source_select != RPD_SRC_RXEND
        |=> cap == $past(cnt) && cnt == 8'h00 && remote_irq)
        else $error("measurement end not captured");

    a_ovf_event: assert property (
        active && !meas_end && !ovf && tick && gate
        && cnt == CNT_MAX
        |=> ovf && remote_irq && cnt == 8'h00 ##1 cnt == 8'h00)
        else $error("overflow handling wrong");

    a_ovf_restart: assert property (
        ovf && wr_b && wr_data[B_RUN_BIT] |=> !ovf)
        else $error("run write did not clear overflow");

    a_rx_bit: assert property (
        active && meas_end && irq_source_select == RPD_SRC_RXEND
        |=> rbuf[0] == $past(bit_dec)
            && remote_irq == (bcnt == BCNT_FRAME))
        else $error("decoded bit or frame interrupt wrong");

    a_bcnt_reload: assert property (
        active && meas_end && irq_source_select == RPD_SRC_RXEND
        && bcnt == BCNT_FRAME |=> bcnt == BCNT_RELOAD)
        else $error("bit count not reloaded");

    a_idle_quiet: assert property (
        !preproc_enable [*2] |=> !remote_irq && cnt == 8'h00)
        else $error("disabled block active");

    a_both_edges: assert property (
        active && irq_source_select == RPD_SRC_BOTH && (rise || fall)
        |=> remote_irq && cap == $past(cnt))
        else $error("both-edge capture missed");

    a_filter_bypass: assert property (
        noise_filter_time == 3'h0 |=> filt == $past(remote_input))
        else $error("disabled filter not transparent");

    a_status_read: assert property (
        rd_en && addr == OFS_STAT
        |=> rd_data == {$past(bcnt), 1'b0, $past(ovf),
                        $past(bit_dec), $past(filt)})
        else $error("status read wrong");

    a_tick_only: assert property (
        active && !meas_end && !tick |=> $stable(cnt))
        else $error("counter moved without tick");

    a_gate_hold: assert property (
        active && !meas_end && !gate |=> $stable(cnt))
        else $error("counter moved outside gated level");

    c_overflow: cover property (active ##1 ovf);
    c_frame:    cover property (
        irq_source_select == RPD_SRC_RXEND && remote_irq);
    c_both:     cover property (
        irq_source_select == RPD_SRC_BOTH && remote_irq ##[1:300]
        remote_irq);
    c_reload:   cover property (
        bcnt == BCNT_FRAME ##[1:1000] bcnt == BCNT_RELOAD);

endmodule

//--- bench/rpd_ir_rx_model.sv
// Model of the demodulated infrared receiver output
`timescale 1ns/1ps
module rpd_ir_rx_model (
    input  wire logic clk,   // Bench clock
    output logic      level  // Demodulated remote signal
);
    // ****************************************
    // Push-pull output, idles low between frames
    // ****************************************
    initial level = 1'b0;

    // Hold one level for n cycles, changed just after an edge
    task automatic drive(input logic v, input int n);
        @(posedge clk);
        level <= v;
        repeat (n - 1) @(posedge clk);
    endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the remote pulse decoder
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("[FAIL] %0t %s", $time, msg); end end
module testbench;
    import rpd_pkg::*;
    typedef struct {logic [7:0] lo; logic [7:0] hi; logic [7:0] m;} rpd_exp_t;
    logic        sys_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic [11:0] addr    = 12'h000;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [7:0]  rd_data;
    logic        remote_input;
    logic        remote_irq;
    logic        rd_pend = 1'b0;
    rpd_exp_t    exp_q[$];
    rpd_exp_t    e;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          irq_cnt     = 0;
    int          base;
    int          div;
    int          flim;
    logic [7:0]  v;

    always #5 sys_clk = ~sys_clk;

    rpd_top #(.NF_SHIFT(8)) i_dut (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .addr         (addr),
        .wr_data      (wr_data),
        .wr_en        (wr_en),
        .rd_en        (rd_en),
        .rd_data      (rd_data),
        .remote_input (remote_input),
        .remote_irq   (remote_irq)
    );
    rpd_ir_rx_model i_rx (.clk(sys_clk), .level(remote_input));

    // ****************************************
    // Result watchers
    // ****************************************
    always @(posedge sys_clk) begin
        rd_pend <= rd_en;
        if (remote_irq === 1'b1) irq_cnt++;
    end
    always @(negedge sys_clk) begin
        if (rd_pend) begin
            e = exp_q.pop_front();
            `CHK(((rd_data & e.m) >= e.lo) && ((rd_data & e.m) <= e.hi),
                 1'b1, "read value")
        end
    end

    // ****************************************
    // Bus and helper tasks
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] lo,
                      input logic [7:0] hi, input logic [7:0] m = 8'hFF);
        rpd_exp_t x;
        x.lo = lo;
        x.hi = hi;
        x.m  = m;
        exp_q.push_back(x);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
    endtask
    task automatic irqs(input int n);
        repeat (4) @(posedge sys_clk);
        `CHK(irq_cnt - base, n, "irq count")
        base = irq_cnt;
    endtask
    task automatic done(input string name);
        wr(OFS_CTRL_B, 8'h00);
        repeat (4) @(posedge sys_clk);
        base = irq_cnt;
        $display("test %s finished", name);
    endtask
    task automatic end_of_test;
        repeat (3) @(posedge sys_clk);
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h901B));
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(OFS_CTRL_A, 8'h00, 8'h00);
        rd(OFS_CTRL_B, 8'h00, 8'h00);
        rd(OFS_CAP, 8'h00, 8'h00);
        rd(OFS_BUF, 8'h00, 8'h00);
        rd(OFS_STAT, 8'h00, 8'h00, 8'hF7);
        rd(12'hFED, 8'h00, 8'h00);
        wr(OFS_CAP, 8'h5A);
        wr(OFS_BUF, 8'hA5);
        rd(OFS_CAP, 8'h00, 8'h00);
        rd(OFS_BUF, 8'h00, 8'h00);
        v = 8'($urandom);
        wr(OFS_CTRL_A, v);
        rd(OFS_CTRL_A, v, v);
        v = 8'($urandom) & 8'hF3;
        wr(OFS_CTRL_B, v);
        rd(OFS_CTRL_B, v, v);
        wr(OFS_CTRL_A, 8'h00);
        done("registers");
        for (int s = 0; s < 3; s++) begin
            wr(OFS_CTRL_A, {2'b00, 1'b0, 2'(s), 3'h0});
            wr(OFS_CTRL_B, s == 1 ? 8'h0D : 8'h0C);
            repeat (3) begin
                i_rx.drive(1'b1, 40);
                i_rx.drive(1'b0, 40);
            end
            irqs(s == 2 ? 6 : 3);
            done("edge source");
        end
        for (int c = 0; c < 4; c++) begin
            div = 64 << (2 * c);
            wr(OFS_CTRL_A, {2'(c), 1'b0, 2'b00, 3'h0});
            wr(OFS_CTRL_B, 8'h0E);
            i_rx.drive(1'b1, div * 4 + div / 2);
            i_rx.drive(1'b0, 100);
            i_rx.drive(1'b1, 20);
            rd(OFS_CAP, 8'h04, 8'h05);
            done("count clock");
        end
        for (int p = 0; p < 2; p++) begin
            wr(OFS_CTRL_A, {2'b00, 1'(p), 2'b00, 3'h0});
            wr(OFS_CTRL_B, 8'h0E);
            repeat (2) begin
                i_rx.drive(1'b1, p ? 200 : 352);
                i_rx.drive(1'b0, p ? 352 : 200);
            end
            i_rx.drive(!p, 20);
            rd(OFS_CAP, 8'h05, 8'h06);
            i_rx.drive(1'b0, 20);
            done("polarity");
        end
        wr(OFS_CTRL_A, 8'h10);
        wr(OFS_CTRL_B, 8'h0F);
        i_rx.drive(1'b1, 30);
        i_rx.drive(1'b0, 416);
        i_rx.drive(1'b1, 224);
        rd(OFS_CAP, 8'h06, 8'h07);
        i_rx.drive(1'b0, 30);
        rd(OFS_CAP, 8'h03, 8'h04);
        irqs(4);
        done("both edges");
        for (int n = 1; n < 8; n++) begin
            // Filter limit with the exponent shortened by 8
            flim = 7 << (n == 7 ? 3 : (n == 6 ? 2 : 0));
            wr(OFS_CTRL_A, {2'b00, 1'b0, 2'b10, 3'(n)});
            wr(OFS_CTRL_B, 8'h0C);
            i_rx.drive(1'b1, flim - 1);
            i_rx.drive(1'b0, 20);
            irqs(0);
            i_rx.drive(1'b1, flim + 5);
            rd(OFS_STAT, 8'h01, 8'h01, 8'h01);
            i_rx.drive(1'b0, flim + 5);
            irqs(2);
            done("filter");
        end
        wr(OFS_CTRL_A, 8'h10);
        wr(OFS_CTRL_B, 8'h08);
        i_rx.drive(1'b1, 40);
        i_rx.drive(1'b0, 40);
        irqs(0);
        wr(OFS_CTRL_B, 8'h04);
        i_rx.drive(1'b1, 40);
        i_rx.drive(1'b0, 40);
        irqs(0);
        done("gating");
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_B, 8'h0C);
        for (int t = 0; t < 17000 && irq_cnt == base; t++)
            @(posedge sys_clk);
        irqs(1);
        rd(OFS_STAT, 8'h04, 8'h04, 8'h04);
        wr(OFS_CTRL_B, 8'h0C);
        rd(OFS_STAT, 8'h00, 8'h00, 8'h04);
        done("overflow");
        v = 8'($urandom);
        wr(OFS_CTRL_B, 8'h20);
        wr(OFS_CTRL_A, 8'h18);
        wr(OFS_CTRL_B, 8'h2C);
        for (int i = 7; i >= 0; i--) begin
            i_rx.drive(1'b0, v[i] ? 2972 : 924);
            i_rx.drive(1'b1, 100);
        end
        irqs(1);
        rd(OFS_BUF, v, v);
        rd(OFS_STAT, 8'h80, 8'h80, 8'hF0);
        i_rx.drive(1'b0, 200);
        i_rx.drive(1'b1, 50);
        rd(OFS_STAT, 8'h10, 8'h10, 8'hF0);
        i_rx.drive(1'b0, 20);
        done("receive end");
        end_of_test();
    end
endmodule
